//--- design/serial_target.sv
`timescale 1ns/1ns
`default_nettype none
module serial_target
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_oe_n,
  reg_access_if.target regs
);
  import pmic_pkg::*;

  typedef enum logic [2:0]
  {
    st_idle = 3'b000,
    st_devaddr = 3'b001,
    st_pointer = 3'b010,
    st_write = 3'b011,
    st_ack = 3'b100,
    st_read = 3'b101,
    st_master_ack = 3'b110,
    st_read_load = 3'b111
  } target_state_type;

  typedef struct packed
  {
    target_state_type st;
    target_state_type after;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wr;
    logic drive;
    logic scl_q;
    logic sda_q;
  } target_type;

  target_type s;
  target_type next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] byte_in;

  assign scl_rise = scl & ~s.scl_q;
  assign scl_fall = ~scl & s.scl_q;
  assign start_seen = scl & s.scl_q & s.sda_q & ~sda_in;
  assign stop_seen = scl & s.scl_q & ~s.sda_q & sda_in;
  assign byte_in = {s.shreg[6:0], sda_in};

  // ----------------------------------------
  // Bus sequencing
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.scl_q = scl;
    next_s.sda_q = sda_in;
    next_s.wr = 1'b0;
    if (start_seen)
    begin
      next_s.st = st_devaddr;
      next_s.bitcnt = 3'd0;
      next_s.drive = 1'b0;
    end
    else if (stop_seen)
    begin
      next_s.st = st_idle;
      next_s.drive = 1'b0;
    end
    else
    begin
      case (s.st)
        st_devaddr, st_pointer, st_write:
        begin
          if (scl_rise)
          begin
            next_s.shreg = byte_in;
            next_s.bitcnt = s.bitcnt + 3'd1;
            if (s.bitcnt == 3'd7)
            begin
              next_s.st = st_ack;
              if (s.st == st_devaddr)
              begin
                next_s.after = byte_in[0] ? st_read : st_pointer;
                if (byte_in[7:1] != target_address)
                begin
                  next_s.st = st_idle;
                end
              end
              else if (s.st == st_pointer)
              begin
                next_s.ptr = byte_in;
                next_s.after = st_write;
              end
              else
              begin
                next_s.wr = 1'b1;
                next_s.waddr = s.ptr;
                next_s.wdata = byte_in;
                next_s.ptr = s.ptr + 8'd1;
                next_s.after = st_write;
              end
            end
          end
        end
        st_ack:
        begin
          if (scl_fall)
          begin
            next_s.drive = ~s.drive;
            if (s.drive)
            begin
              next_s.st = s.after;
              next_s.bitcnt = 3'd0;
              if (s.after == st_read)
              begin
                next_s.shreg = regs.rd_data;
                next_s.drive = ~regs.rd_data[7];
                next_s.ptr = s.ptr + 8'd1;
              end
            end
          end
        end
        st_read:
        begin
          if (scl_fall)
          begin
            next_s.bitcnt = s.bitcnt + 3'd1;
            next_s.shreg = {s.shreg[6:0], 1'b0};
            next_s.drive = ~s.shreg[6];
            if (s.bitcnt == 3'd7)
            begin
              next_s.drive = 1'b0;
              next_s.st = st_master_ack;
            end
          end
        end
        st_master_ack:
        begin
          if (scl_rise)
          begin
            next_s.st = sda_in ? st_idle : st_read_load;
          end
        end
        st_read_load:
        begin
          if (scl_fall)
          begin
            next_s.st = st_read;
            next_s.bitcnt = 3'd0;
            next_s.shreg = regs.rd_data;
            next_s.drive = ~regs.rd_data[7];
            next_s.ptr = s.ptr + 8'd1;
          end
        end
        default:
        begin
          next_s.drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s <= '{st: st_idle, after: st_idle, scl_q: 1'b1, sda_q: 1'b1, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sda_oe_n = ~s.drive;
  assign regs.wr_en = s.wr;
  assign regs.wr_addr = s.waddr;
  assign regs.wr_data = s.wdata;
  assign regs.rd_addr = s.ptr;
endmodule // serial_target
`default_nettype wire

//--- shared/pmic_pkg.sv
package pmic_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] addr_charger_status = 8'h0a;
  localparam logic [7:0] addr_regulator_enable = 8'h0b;
  localparam logic [7:0] addr_regulator_one_two = 8'h0c;
  localparam logic [7:0] addr_fine_four = 8'h0e;
  localparam logic [7:0] addr_fine_five = 8'h0f;
  localparam logic [7:0] addr_fine_three = 8'h16;
  localparam logic [7:0] addr_gpio_three = 8'h1c;
  localparam logic [7:0] addr_power_good_action = 8'h20;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] reset_regulator_enable = 8'hfd;
  localparam logic [7:0] reset_regulator_one_two = 8'hcf;
  localparam logic [7:0] reset_fine_regulator = 8'h80;
  localparam logic [7:0] reset_gpio_three = 8'h00;
  localparam logic [7:0] reset_power_good_action = 8'hff;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int bit_en_one = 7;
  localparam int bit_en_two = 6;
  localparam int bit_en_three = 5;
  localparam int bit_en_four = 4;
  localparam int bit_en_five = 3;
  localparam int bit_en_card = 1;
  localparam int bit_card_low = 2;
  localparam int bit_en_rtc = 0;
  localparam int bit_disch_one = 7;
  localparam int bit_disch_two = 3;
  localparam int bit_disch_fine = 7;
  localparam int bit_en_zero = 5;

  // Monitored regulator index
  localparam int num_monitored = 7;
  localparam int idx_one = 0;
  localparam int idx_two = 1;
  localparam int idx_three = 2;
  localparam int idx_four = 3;
  localparam int idx_five = 4;
  localparam int idx_card = 5;
  localparam int idx_zero = 6;
  localparam int num_discharge = 5;

  // Status bits that raise a change request
  localparam int num_status_event = 7;

  // Target bus address, arbitrary value
  localparam logic [6:0] target_address = 7'h2a;

endpackage

//--- shared/reg_access_if.sv
`timescale 1ns/1ns
`default_nettype none
interface reg_access_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  modport target
  (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_addr,
    input rd_data
  );

  modport bank
  (
    input wr_en,
    input wr_addr,
    input wr_data,
    input rd_addr,
    output rd_data
  );
endinterface
`default_nettype wire

//--- design/charger_status_ldo_control.sv
`timescale 1ns/1ns
`default_nettype none
module charger_status_ldo_control
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic supplement_enter,
  input wire logic supplement_exit,
  input wire logic load_over_limit,
  input wire logic selected_source_flag,
  input wire logic thermal_powerpath_loop_flag,
  input wire logic wall_input_present,
  input wire logic usb_input_present,
  input wire logic charge_state_hi,
  input wire logic charge_state_lo,
  input wire logic input_overvoltage_flag,
  input wire logic [pmic_pkg::num_monitored-1:0] power_below_good,
  output logic [pmic_pkg::num_monitored-1:0] regulator_enable,
  output logic rtc_regulator_enable,
  output logic card_voltage_low_select,
  output logic input_indicator_regulator,
  output logic [pmic_pkg::num_discharge-1:0] discharge_switch,
  output logic [pmic_pkg::num_monitored-1:0] power_good_fail,
  output logic power_good_interrupt,
  output logic power_good_mode_request,
  output logic status_change_request
);
  import pmic_pkg::*;

  typedef struct packed
  {
    logic [7:0] en_reg;
    logic [7:0] one_two_reg;
    logic [7:0] three_reg;
    logic [7:0] four_reg;
    logic [7:0] five_reg;
    logic [7:0] gpio_reg;
    logic [7:0] action_reg;
    logic supplement;
    logic [num_status_event-1:0] status_prev;
    logic [num_monitored-1:0] enable;
    logic rtc_en;
    logic card_sel;
    logic indicator;
    logic [num_discharge-1:0] discharge;
    logic [num_monitored-1:0] pg_fail;
    logic pg_irq;
    logic pg_mode;
    logic change;
  } bank_type;

  bank_type s;
  bank_type next_s;
  reg_access_if regs ();
  logic [7:0] status_word;
  logic [num_monitored-1:0] en_vec;
  logic [num_discharge-1:0] disch_en_vec;
  logic [num_monitored-1:0] pg_raw;
  logic [num_discharge-1:0] disch_raw;
  genvar g;

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  function automatic logic [7:0] read_decode(input logic [7:0] addr,
                                              input bank_type b,
                                              input logic [7:0] status);
    case (addr)
      addr_charger_status: read_decode = status;
      addr_regulator_enable: read_decode = b.en_reg;
      addr_regulator_one_two: read_decode = b.one_two_reg;
      addr_fine_three: read_decode = b.three_reg;
      addr_fine_four: read_decode = b.four_reg;
      addr_fine_five: read_decode = b.five_reg;
      addr_gpio_three: read_decode = b.gpio_reg;
      addr_power_good_action: read_decode = b.action_reg;
      default: read_decode = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // Serial register access
  // ----------------------------------------
  serial_target target_inst
  (
    .clk(clk),
    .resetn(resetn),
    .scl(scl),
    .sda_in(sda_in),
    .sda_oe_n(sda_oe_n),
    .regs(regs.target)
  );

  // ----------------------------------------
  // Live charger status word
  // ----------------------------------------
  assign status_word = {s.supplement, selected_source_flag, thermal_powerpath_loop_flag,
                        wall_input_present, usb_input_present,
                        charge_state_hi, charge_state_lo, input_overvoltage_flag};
  assign regs.rd_data = read_decode(regs.rd_addr, s, status_word);

  // ----------------------------------------
  // Enable bits gathered per monitored regulator
  // ----------------------------------------
  assign en_vec = {s.gpio_reg[bit_en_zero], s.en_reg[bit_en_card], s.en_reg[bit_en_five],
                   s.en_reg[bit_en_four], s.en_reg[bit_en_three], s.en_reg[bit_en_two],
                   s.en_reg[bit_en_one]};
  assign disch_en_vec = {s.five_reg[bit_disch_fine], s.four_reg[bit_disch_fine],
                         s.three_reg[bit_disch_fine], s.one_two_reg[bit_disch_two],
                         s.one_two_reg[bit_disch_one]};

  // ----------------------------------------
  // Per-regulator power-good and discharge
  // ----------------------------------------
  generate
    for (g = 0; g < num_monitored; g = g + 1)
    begin : pg_gen
      assign pg_raw[g] = power_below_good[g] & s.enable[g];
    end
    for (g = 0; g < num_discharge; g = g + 1)
    begin : disch_gen
      assign disch_raw[g] = ~en_vec[g] & disch_en_vec[g];
    end
  endgenerate

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_s = s;
    if (regs.wr_en)
    begin
      case (regs.wr_addr)
        addr_regulator_enable: next_s.en_reg = regs.wr_data;
        addr_regulator_one_two: next_s.one_two_reg = regs.wr_data;
        addr_fine_three: next_s.three_reg = regs.wr_data;
        addr_fine_four: next_s.four_reg = regs.wr_data;
        addr_fine_five: next_s.five_reg = regs.wr_data;
        addr_gpio_three: next_s.gpio_reg = regs.wr_data;
        addr_power_good_action: next_s.action_reg = regs.wr_data;
        default: next_s.en_reg = s.en_reg;
      endcase
    end
    // ----------------------------------------
    // Supplement mode with hysteresis
    // ----------------------------------------
    if (supplement_enter || load_over_limit)
    begin
      next_s.supplement = 1'b1;
    end
    else if (supplement_exit)
    begin
      next_s.supplement = 1'b0;
    end
    next_s.status_prev = status_word[num_status_event-1:0];
    next_s.change = |(status_word[num_status_event-1:0] ^ s.status_prev);
    next_s.enable = en_vec;
    next_s.rtc_en = s.en_reg[bit_en_rtc];
    next_s.card_sel = s.en_reg[bit_card_low];
    next_s.indicator = wall_input_present | usb_input_present;
    next_s.discharge = disch_raw;
    next_s.pg_fail = pg_raw;
    next_s.pg_irq = |(s.pg_fail & s.action_reg[num_monitored-1:0]);
    next_s.pg_mode = |(s.pg_fail & ~s.action_reg[num_monitored-1:0]);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.status_prev <= status_word[num_status_event-1:0];
      s.en_reg <= reset_regulator_enable;
      s.one_two_reg <= reset_regulator_one_two;
      s.three_reg <= reset_fine_regulator;
      s.four_reg <= reset_fine_regulator;
      s.five_reg <= reset_fine_regulator;
      s.gpio_reg <= reset_gpio_three;
      s.action_reg <= reset_power_good_action;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sda_out = 1'b0;
  assign regulator_enable = s.enable;
  assign rtc_regulator_enable = s.rtc_en;
  assign card_voltage_low_select = s.card_sel;
  assign input_indicator_regulator = s.indicator;
  assign discharge_switch = s.discharge;
  assign power_good_fail = s.pg_fail;
  assign power_good_interrupt = s.pg_irq;
  assign power_good_mode_request = s.pg_mode;
  assign status_change_request = s.change;
endmodule // charger_status_ldo_control
`default_nettype wire

//--- test/i2c_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Bus master with open drain data
// ----
module i2c_host_model
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  import pmic_pkg::*;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick();
    repeat (4) @(negedge clk);
  endtask
  task automatic open_frame();
    sda_low = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask
  task automatic close_frame();
    sda_low = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sda_low = 1'b0;
    tick();
  endtask
  task automatic put_bit(input logic b, output logic r);
    sda_low = ~b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    tick();
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(d[i], q[i]);
    put_bit(mack, ack);
  endtask
  task automatic probe(input logic [7:0] d, output logic ack);
    logic [7:0] q;
    open_frame();
    xfer(d, 1'b1, q, ack);
    close_frame();
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    open_frame();
    xfer({target_address, 1'b0}, 1'b1, q, k[0]);
    xfer(a, 1'b1, q, k[1]);
    xfer(d, 1'b1, q, k[2]);
    close_frame();
    ok = (k === 3'h0);
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    logic [7:0] junk;
    logic k;
    open_frame();
    xfer({target_address, 1'b0}, 1'b1, junk, k);
    xfer(a, 1'b1, junk, k);
    open_frame();
    xfer({target_address, 1'b1}, 1'b1, junk, k);
    xfer(8'hff, 1'b1, q, k);
    close_frame();
  endtask
endmodule // i2c_host_model
`default_nettype wire

//--- test/charger_status_ldo_control_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Port checker
// ----
module charger_status_ldo_control_monitor
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_oe_n,
  input wire logic selected_source_flag,
  input wire logic thermal_powerpath_loop_flag,
  input wire logic wall_input_present,
  input wire logic usb_input_present,
  input wire logic charge_state_hi,
  input wire logic charge_state_lo,
  input wire logic input_overvoltage_flag,
  input wire logic [pmic_pkg::num_monitored-1:0] power_below_good,
  input wire logic [pmic_pkg::num_monitored-1:0] regulator_enable,
  input wire logic rtc_regulator_enable,
  input wire logic input_indicator_regulator,
  input wire logic [pmic_pkg::num_discharge-1:0] discharge_switch,
  input wire logic [pmic_pkg::num_monitored-1:0] power_good_fail,
  input wire logic power_good_interrupt,
  input wire logic power_good_mode_request,
  input wire logic status_change_request
);
  import pmic_pkg::*;
  logic [6:0] st;
  logic [6:0] st_d1;
  logic [6:0] st_d2;
  logic [6:0] st_d3;
  assign st = {selected_source_flag, thermal_powerpath_loop_flag, wall_input_present,
               usb_input_present, charge_state_hi, charge_state_lo, input_overvoltage_flag};
  always_ff @(posedge clk)
  begin
    st_d1 <= st;
    st_d2 <= st_d1;
    st_d3 <= st_d2;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  fail_gating_a:
    assert property ($past(resetn) && $past(regulator_enable) == regulator_enable
      |-> power_good_fail == $past(power_below_good & regulator_enable))
      else $error("power good fail mismatch");
  pg_route_a:
    assert property ($past(resetn) && $past(power_good_fail) != '0
      |-> power_good_interrupt || power_good_mode_request)
      else $error("power good fail not routed");
  pg_quiet_a:
    assert property ($past(resetn) && $past(power_good_fail) == '0
      |-> !power_good_interrupt && !power_good_mode_request)
      else $error("power good action without fail");
  indicator_follow_a:
    assert property ($past(resetn)
      |-> input_indicator_regulator == $past(wall_input_present | usb_input_present))
      else $error("indicator regulator wrong");
  discharge_off_a:
    assert property ((discharge_switch & regulator_enable[num_discharge-1:0]) == '0)
      else $error("discharge on enabled regulator");
  change_cause_a:
    assert property (status_change_request |-> st != st_d1 || st_d1 != st_d2 || st_d2 != st_d3)
      else $error("change request without cause");
  change_seen_a:
    assert property (st != st_d1 |-> ##[0:4] status_change_request)
      else $error("status change missed");
  reset_enables_a:
    assert property ($rose(resetn) |-> ##2 regulator_enable == 7'h1f && rtc_regulator_enable)
      else $error("enables wrong after reset");
  sda_timing_a:
    assert property (!$stable(sda_oe_n) |-> !scl)
      else $error("data changed with clock high");
endmodule // charger_status_ldo_control_monitor
bind charger_status_ldo_control charger_status_ldo_control_monitor monitor_i (.*);
`default_nettype wire

//--- test/charger_status_ldo_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----
// Bench
// ----
module charger_status_ldo_control_tb_top;
  import pmic_pkg::*;
  typedef struct packed
  {
    logic [2:0] sup;
    logic [6:0] st;
    logic [7:0] exp;
  } row_type;
  row_type rows [7] = '{'{3'h4, 7'h18, 8'h98}, '{3'h0, 7'h12, 8'h92}, '{3'h2, 7'h54, 8'h54},
    '{3'h0, 7'h2e, 8'h2e}, '{3'h1, 7'h19, 8'h99}, '{3'h6, 7'h10, 8'h90}, '{3'h2, 7'h08, 8'h08}};
  logic [7:0] raddr [7] = '{8'h0b, 8'h0c, 8'h16, 8'h0e, 8'h0f, 8'h1c, 8'h20};
  logic [7:0] rval [7] = '{8'hfd, 8'hcf, 8'h80, 8'h80, 8'h80, 8'h00, 8'hff};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] sup = 3'h0;
  logic [6:0] st = 7'h00;
  logic [6:0] below = 7'h00;
  logic scl, host_low, sda, sda_oe_n, rtc_en, card_low, indicator, pg_int, pg_mode, change;
  logic [6:0] reg_en;
  logic [6:0] pg_fail;
  logic [4:0] disch;
  logic sda_drv;
  logic [7:0] q;
  logic ok;
  int miscompares = 0;
  int total_checks = 0;
  int n;
  assign sda = ~host_low & sda_oe_n;
  always #5 clk = ~clk;
  i2c_host_model host (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  charger_status_ldo_control dut (.clk(clk), .resetn(resetn), .scl(scl), .sda_in(sda),
    .sda_out(sda_drv), .sda_oe_n(sda_oe_n), .supplement_enter(sup[2]), .supplement_exit(sup[1]),
    .load_over_limit(sup[0]), .selected_source_flag(st[6]), .thermal_powerpath_loop_flag(st[5]),
    .wall_input_present(st[4]), .usb_input_present(st[3]), .charge_state_hi(st[2]),
    .charge_state_lo(st[1]), .input_overvoltage_flag(st[0]), .power_below_good(below),
    .regulator_enable(reg_en), .rtc_regulator_enable(rtc_en),
    .card_voltage_low_select(card_low), .input_indicator_regulator(indicator),
    .discharge_switch(disch), .power_good_fail(pg_fail), .power_good_interrupt(pg_int),
    .power_good_mode_request(pg_mode), .status_change_request(change));
  task automatic test_done();
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", name, e, s);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ok);
    check("ack", 8'h01, {7'h00, ok});
  endtask
  task automatic settle(input logic [6:0] b);
    @(negedge clk);
    below = b;
    repeat (3) @(negedge clk);
  endtask
  task automatic pulses();
    n = 0;
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk);
      if (change === 1'b1)
        n++;
    end
  endtask
  task automatic do_reset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  initial
  begin
    repeat (90000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial
  begin
    do_reset();
    for (int r = 0; r < 7; r++)
    begin
      @(negedge clk);
      sup = rows[r].sup;
      st = rows[r].st;
      repeat (3) @(negedge clk);
      host.read_reg(addr_charger_status, q);
      check("status", rows[r].exp, q);
    end
    check("sda out", 8'h00, {7'h00, sda_drv});
    wr(addr_regulator_enable, 8'h00);
    check("enable", 8'h00, {1'b0, reg_en});
    check("discharge", 8'h1f, {3'h0, disch});
    wr(addr_regulator_one_two, 8'h4f);
    wr(addr_fine_three, 8'h00);
    check("discharge", 8'h1a, {3'h0, disch});
    wr(addr_regulator_enable, 8'hff);
    check("enable", 8'h3f, {1'b0, reg_en});
    check("rtc card", 8'h03, {6'h00, rtc_en, card_low});
    check("discharge", 8'h00, {3'h0, disch});
    wr(addr_gpio_three, 8'h20);
    check("enable", 8'h7f, {1'b0, reg_en});
    settle(7'h03);
    check("fail", 8'h03, {1'b0, pg_fail});
    check("pg out", 8'h02, {6'h00, pg_int, pg_mode});
    wr(addr_power_good_action, 8'hfe);
    check("pg out", 8'h03, {6'h00, pg_int, pg_mode});
    settle(7'h01);
    check("pg out", 8'h01, {6'h00, pg_int, pg_mode});
    settle(7'h00);
    host.write_reg(addr_charger_status, 8'hff, ok);
    @(negedge clk);
    st = 7'h14;
    repeat (3) @(negedge clk);
    host.read_reg(addr_charger_status, q);
    check("status", 8'h14, q);
    host.read_reg(8'h30, q);
    check("unmapped", 8'h00, q);
    host.probe(8'h10, ok);
    check("nack", 8'h01, {7'h00, ok});
    st = 7'h00;
    repeat (3) @(negedge clk);
    check("indicator", 8'h00, {7'h00, indicator});
    st = 7'h08;
    repeat (3) @(negedge clk);
    check("indicator", 8'h01, {7'h00, indicator});
    sup = 3'h4;
    pulses();
    check("sup pulses", 8'h00, 8'(n));
    st = 7'h09;
    pulses();
    check("pulses", 8'h01, 8'(n));
    st = 7'h14;
    sup = 3'h0;
    repeat (6) @(negedge clk);
    do_reset();
    for (int i = 0; i < 7; i++)
    begin
      host.read_reg(raddr[i], q);
      check("reset value", rval[i], q);
    end
    wr(addr_regulator_enable, 8'h00);
    check("discharge", 8'h1f, {3'h0, disch});
    test_done();
  end
endmodule // charger_status_ldo_control_tb_top
`default_nettype wire
